/* File: logic/svma_pkg.sv */
// constants and types of the servo motion axis counters
// assumes one system clock at 250 MHz and synchronous inputs
package svma_pkg;
    // ************************************************
    // widths
    // ************************************************
    localparam int AXIS_W = 32;
    localparam int VER_W = 16;
    localparam int CODE_W = 8;
    localparam logic [AXIS_W-1:0] AXIS_RST = 32'h0000_0000;
    localparam logic signed [AXIS_W-1:0] AXIS_ONE = 32'sh0000_0001;
    // ************************************************
    // monitor codes
    // ************************************************
    localparam logic [CODE_W-1:0] MON_FW_VERSION = 8'h60;
    localparam logic [CODE_W-1:0] MON_ALARM_CODE = 8'h6F;
    localparam logic [CODE_W-1:0] MON_PANEL_VALUE = 8'h7B;
    localparam int VER_LO = 0;
    localparam int VER_HI = 16;
    // ************************************************
    // position units
    // ************************************************
    localparam logic [AXIS_W-1:0] COUNTS_PER_REV = 32'h0013_8800;
    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int TIME_AXIS_MS = 1;
    localparam int NS_PER_MS = 1000000;
    localparam int MS_CYCLES = TIME_AXIS_MS * NS_PER_MS / CLK_PERIOD_NS;
    // ************************************************
    // types
    // ************************************************
    typedef enum logic [1:0] {PF_STEP_DIR, PF_CW_CCW, PF_QUAD} svma_pfmt_e;
    typedef enum logic {CS_ENCODER, CS_PULSE} svma_csrc_e;
    typedef enum logic {WS_PULSE, WS_CAPTURE} svma_wsel_e;
    typedef enum logic {PS_IDLE, PS_RUN} svma_path_e;
endpackage : svma_pkg

/* File: logic/svma_axis_counters.sv */
// motion axis counters, gear scaling and monitor words of a servo drive
// assumes synchronous inputs, one-cycle step strobes, firmware path table
`timescale 1ns/1ps

module svma_axis_counters
    import svma_pkg::*;
#(
    parameter int MS_CYCLES_P = svma_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic cmd_pulse_a,
    input wire logic cmd_pulse_b,
    input wire svma_pkg::svma_pfmt_e pulse_format_param,
    input wire logic [svma_pkg::AXIS_W-1:0] gear_numerator_param,
    input wire logic [svma_pkg::AXIS_W-1:0] gear_denominator_param,
    input wire svma_pkg::svma_csrc_e capture_axis_param,
    input wire logic capture_strobe_input,
    input wire logic stored_path_mode,
    input wire logic path_trigger_input,
    input wire logic path_select_bit0,
    input wire logic path_select_bit1,
    input wire logic path_select_bit2,
    input wire logic [svma_pkg::AXIS_W-1:0] path_target,
    input wire logic axis_wr,
    input wire svma_pkg::svma_wsel_e axis_wsel,
    input wire logic [svma_pkg::AXIS_W-1:0] axis_wdata,
    input wire logic [svma_pkg::VER_W-1:0] dsp_fw_version,
    input wire logic [svma_pkg::VER_W-1:0] pld_fw_version,
    input wire logic [svma_pkg::VER_W-1:0] alarm_code,
    input wire logic [svma_pkg::CODE_W-1:0] panel_code,
    input wire logic mon_rd,
    input wire logic [svma_pkg::CODE_W-1:0] mon_code,
    output logic [svma_pkg::AXIS_W-1:0] mon_data,
    output logic mon_valid,
    output logic mon_unknown,
    output logic [svma_pkg::AXIS_W-1:0] panel_monitor_value_word,
    output logic signed [svma_pkg::AXIS_W-1:0] encoder_axis_param,
    output logic [svma_pkg::AXIS_W-1:0] enc_rev_count,
    output logic signed [svma_pkg::AXIS_W-1:0] pulse_axis_param,
    output logic signed [svma_pkg::AXIS_W-1:0] capture_axis,
    output logic signed [svma_pkg::AXIS_W-1:0] capture_data,
    output logic capture_taken,
    output logic capture_ok,
    output logic signed [svma_pkg::AXIS_W-1:0] path_axis,
    output logic path_busy,
    output logic path_done,
    output logic [2:0] path_index,
    output logic [svma_pkg::AXIS_W-1:0] time_axis
);
    import svma_pkg::*;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic signed [AXIS_W-1:0] ext(
        input logic signed [1:0] d);
        ext = {{(AXIS_W-2){d[1]}}, d};
    endfunction : ext

    function automatic logic [AXIS_W-1:0] lookup(
        input logic [CODE_W-1:0] code,
        input logic [AXIS_W-1:0] panel);
        case (code)
            MON_FW_VERSION: lookup = {pld_fw_version, dsp_fw_version};
            MON_ALARM_CODE: lookup = {{(AXIS_W-VER_W){1'b0}}, alarm_code};
            MON_PANEL_VALUE: lookup = panel;
            default: lookup = AXIS_RST;
        endcase
    endfunction : lookup

    function automatic logic known(input logic [CODE_W-1:0] code);
        known = (code == MON_FW_VERSION) || (code == MON_ALARM_CODE) ||
                (code == MON_PANEL_VALUE);
    endfunction : known

    // ************************************************
    // state
    // ************************************************
    logic [31:0] ms_cnt, next_ms_cnt;
    logic ms_tick;
    logic [AXIS_W-1:0] next_time_axis;
    logic signed [AXIS_W:0] resid, next_resid;
    logic signed [AXIS_W-1:0] next_enc;
    logic [AXIS_W-1:0] next_rev;
    logic signed [1:0] enc_delta, pulse_delta, src_delta;
    logic a_prev, b_prev, cap_prev, trg_prev;
    logic signed [AXIS_W-1:0] next_pulse, next_capture, next_cap_data;
    logic next_taken, next_cap_ok;
    svma_path_e path_st, next_path_st;
    logic signed [AXIS_W-1:0] path_end, next_path_end, next_path_axis;
    logic next_path_done;
    logic [2:0] next_path_index, sel;
    logic [AXIS_W-1:0] next_mon_data, next_panel;
    logic next_mon_valid, next_mon_unknown;
    logic trg_rise;
    logic [1:0] quad_prev, quad_cur;

    assign ms_tick = (ms_cnt == 32'(MS_CYCLES_P - 1));
    assign sel = {path_select_bit2, path_select_bit1, path_select_bit0};
    assign trg_rise = path_trigger_input && !trg_prev;
    assign quad_prev = {a_prev, b_prev};
    assign quad_cur = {cmd_pulse_a, cmd_pulse_b};

    // ************************************************
    // time axis and encoder axis
    // ************************************************
    always_comb begin
        next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
        next_time_axis = time_axis + (ms_tick ? 32'h0000_0001 : 32'h0);
        // each forward encoder count adds den, each reverse count subtracts it; each num steps one user unit
        next_resid = resid;
        next_rev = enc_rev_count;
        enc_delta = 2'sb00;
        if (enc_step && !enc_dir) begin
            next_resid = resid + $signed({1'b0, gear_denominator_param});
            next_rev = (enc_rev_count == COUNTS_PER_REV - 32'h1) ?
                AXIS_RST : enc_rev_count + 32'h1;
        end else if (enc_step) begin
            next_resid = resid - $signed({1'b0, gear_denominator_param});
            next_rev = (enc_rev_count == AXIS_RST) ?
                COUNTS_PER_REV - 32'h1 : enc_rev_count - 32'h1;
        end
        if (resid >= $signed({1'b0, gear_numerator_param}) &&
            gear_numerator_param != AXIS_RST) begin
            next_resid = next_resid - $signed({1'b0, gear_numerator_param});
            enc_delta = 2'sb01;
        end else if (resid <= -$signed({1'b0, gear_numerator_param}) &&
            gear_numerator_param != AXIS_RST) begin
            next_resid = next_resid + $signed({1'b0, gear_numerator_param});
            enc_delta = -2'sb01;
        end
        next_enc = encoder_axis_param + ext(enc_delta);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ms_cnt <= 32'h0000_0000;
            time_axis <= AXIS_RST;
            resid <= 33'sh0_0000_0000;
            encoder_axis_param <= AXIS_RST;
            enc_rev_count <= AXIS_RST;
        end else begin
            ms_cnt <= next_ms_cnt;
            time_axis <= next_time_axis;
            resid <= next_resid;
            encoder_axis_param <= next_enc;
            enc_rev_count <= next_rev;
        end
    end

    // ************************************************
    // pulse axis and capture axis
    // ************************************************
    always_comb begin
        pulse_delta = 2'sb00;
        case (pulse_format_param)
            PF_STEP_DIR: begin
                if (cmd_pulse_a && !a_prev) begin
                    pulse_delta = cmd_pulse_b ? -2'sb01 : 2'sb01;
                end
            end
            PF_CW_CCW: begin
                if (cmd_pulse_a && !a_prev) begin
                    pulse_delta = 2'sb01;
                end else if (cmd_pulse_b && !b_prev) begin
                    pulse_delta = -2'sb01;
                end
            end
            PF_QUAD: begin
                case ({quad_prev, quad_cur})
                    4'h1, 4'h7, 4'hE, 4'h8: pulse_delta = 2'sb01;
                    4'h2, 4'hB, 4'hD, 4'h4: pulse_delta = -2'sb01;
                    default: pulse_delta = 2'sb00;
                endcase
            end
            default: pulse_delta = 2'sb00;
        endcase
        next_pulse = pulse_axis_param + ext(pulse_delta);
        if (axis_wr && axis_wsel == WS_PULSE) begin
            next_pulse = axis_wdata;
        end
        // only the two real axes can be the source
        src_delta = (capture_axis_param == CS_ENCODER) ?
            enc_delta : pulse_delta;
        next_capture = capture_axis + ext(src_delta);
        if (axis_wr && axis_wsel == WS_CAPTURE && capture_taken) begin
            next_capture = axis_wdata;
        end
        next_cap_data = capture_data;
        next_taken = capture_taken;
        next_cap_ok = 1'b0;
        if (capture_strobe_input && !cap_prev) begin
            next_cap_data = capture_axis;
            next_taken = 1'b1;
            next_cap_ok = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
            cap_prev <= 1'b0;
            pulse_axis_param <= AXIS_RST;
            capture_axis <= AXIS_RST;
            capture_data <= AXIS_RST;
            capture_taken <= 1'b0;
            capture_ok <= 1'b0;
        end else begin
            a_prev <= cmd_pulse_a;
            b_prev <= cmd_pulse_b;
            cap_prev <= capture_strobe_input;
            pulse_axis_param <= next_pulse;
            capture_axis <= next_capture;
            capture_data <= next_cap_data;
            capture_taken <= next_taken;
            capture_ok <= next_cap_ok;
        end
    end

    // ************************************************
    // path command axis
    // ************************************************
    always_comb begin
        next_path_st = path_st;
        next_path_end = path_end;
        next_path_axis = path_axis;
        next_path_index = path_index;
        next_path_done = 1'b0;
        case (path_st)
            PS_IDLE: begin
                if (stored_path_mode && trg_rise) begin
                    next_path_end = path_target;
                    next_path_index = sel;
                    next_path_st = PS_RUN;
                end
            end
            PS_RUN: begin
                if (path_axis == path_end) begin
                    next_path_st = PS_IDLE;
                    next_path_done = 1'b1;
                end else if (path_axis < path_end) begin
                    next_path_axis = path_axis + AXIS_ONE;
                end else begin
                    next_path_axis = path_axis - AXIS_ONE;
                end
            end
            default: next_path_st = PS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            path_st <= PS_IDLE;
            path_end <= AXIS_RST;
            path_axis <= AXIS_RST;
            path_index <= 3'h0;
            path_busy <= 1'b0;
            path_done <= 1'b0;
            trg_prev <= 1'b0;
        end else begin
            path_st <= next_path_st;
            path_end <= next_path_end;
            path_axis <= next_path_axis;
            path_index <= next_path_index;
            path_busy <= (next_path_st == PS_RUN);
            path_done <= next_path_done;
            trg_prev <= path_trigger_input;
        end
    end

    // ************************************************
    // monitor words
    // ************************************************
    always_comb begin
        next_panel = (panel_code == MON_PANEL_VALUE) ?
            AXIS_RST : lookup(panel_code, AXIS_RST);
        next_mon_valid = mon_rd;
        next_mon_data = mon_rd ?
            lookup(mon_code, panel_monitor_value_word) : mon_data;
        next_mon_unknown = mon_rd ? !known(mon_code) : mon_unknown;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mon_data <= AXIS_RST;
            mon_valid <= 1'b0;
            mon_unknown <= 1'b0;
            panel_monitor_value_word <= AXIS_RST;
        end else begin
            mon_data <= next_mon_data;
            mon_valid <= next_mon_valid;
            mon_unknown <= next_mon_unknown;
            panel_monitor_value_word <= next_panel;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_fw_low;
        mon_rd && mon_code == MON_FW_VERSION |=>
            mon_valid && mon_data[VER_HI-1:VER_LO] == $past(dsp_fw_version);
    endproperty
    a_fw_low: assert property (p_fw_low) else $error("fw low word");

    property p_fw_high;
        mon_rd && mon_code == MON_FW_VERSION |=>
            mon_data[AXIS_W-1:VER_HI] == $past(pld_fw_version);
    endproperty
    a_fw_high: assert property (p_fw_high) else $error("fw high word");

    property p_time_step;
        $changed(time_axis) |-> time_axis == $past(time_axis) + 32'h1;
    endproperty
    a_time_step: assert property (p_time_step) else $error("time step");

    property p_time_rate;
        ms_tick |=> !ms_tick [*2];
    endproperty
    a_time_rate: assert property (p_time_rate) else $error("tick rate");

    property p_time_wrap;
        ms_tick && time_axis == 32'hFFFF_FFFF |=> time_axis == AXIS_RST;
    endproperty
    a_time_wrap: assert property (p_time_wrap) else $error("no wrap");

    property p_enc_ro;
        $changed(encoder_axis_param) |-> $past(enc_delta) != 2'sb00;
    endproperty
    a_enc_ro: assert property (p_enc_ro) else $error("enc moved");

    property p_pulse_wr;
        axis_wr && axis_wsel == WS_PULSE |=>
            pulse_axis_param == $past(axis_wdata);
    endproperty
    a_pulse_wr: assert property (p_pulse_wr) else $error("pulse wr");

    property p_cap_track;
        !(axis_wr && axis_wsel == WS_CAPTURE && capture_taken) |=>
            capture_axis - $past(capture_axis) == ext($past(src_delta));
    endproperty
    a_cap_track: assert property (p_cap_track) else $error("cap track");

    property p_cap_lock;
        axis_wr && axis_wsel == WS_CAPTURE && !capture_taken &&
            src_delta == 2'sb00 |=> $stable(capture_axis);
    endproperty
    a_cap_lock: assert property (p_cap_lock) else $error("cap lock");

    property p_path_start;
        path_st == PS_IDLE && stored_path_mode && trg_rise |=>
            path_busy && path_index == $past(sel);
    endproperty
    a_path_start: assert property (p_path_start) else $error("start");

    property p_alarm;
        mon_rd && mon_code == MON_ALARM_CODE |=>
            mon_data == {16'h0000, $past(alarm_code)};
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm word");
endmodule : svma_axis_counters

/* File: verification/svma_master_model.sv */
// external motion master: command pulses, path select and path trigger
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
module svma_master_model
    import svma_pkg::*;
(
    input wire logic clk_sys,
    output logic cmd_pulse_a,
    output logic cmd_pulse_b,
    output logic path_select_bit0,
    output logic path_select_bit1,
    output logic path_select_bit2,
    output logic path_trigger_input
);
    initial begin
        {cmd_pulse_a, cmd_pulse_b} = 2'b00;
        {path_select_bit2, path_select_bit1, path_select_bit0} = 3'h0;
        path_trigger_input = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : hold
    // ************************************************
    // one pulse unit in the chosen format, lines idle low after
    // ************************************************
    task automatic pulse(input svma_pfmt_e fmt, input logic down);
        case (fmt)
            PF_STEP_DIR: begin
                {cmd_pulse_a, cmd_pulse_b} = {1'b0, down};
                hold(2);
                {cmd_pulse_a, cmd_pulse_b} = {1'b1, down};
                hold(2);
            end
            PF_CW_CCW: begin
                {cmd_pulse_a, cmd_pulse_b} = down ? 2'b01 : 2'b10;
                hold(2);
            end
            default: begin
                // b leads a counts up in the decoder
                {cmd_pulse_a, cmd_pulse_b} = down ? 2'b10 : 2'b01;
                hold(2);
                {cmd_pulse_a, cmd_pulse_b} = 2'b11;
                hold(2);
                {cmd_pulse_a, cmd_pulse_b} = down ? 2'b01 : 2'b10;
                hold(2);
            end
        endcase
        {cmd_pulse_a, cmd_pulse_b} = 2'b00;
        hold(2);
    endtask : pulse
    // ************************************************
    // select settles before the trigger rises
    // ************************************************
    task automatic launch(input logic [2:0] idx);
        {path_select_bit2, path_select_bit1, path_select_bit0} = idx;
        hold(2);
        path_trigger_input = 1'b1;
        hold(2);
        path_trigger_input = 1'b0;
        hold(2);
    endtask : launch
endmodule : svma_master_model

/* File: verification/tb_top.sv */
// self-checking bench of the motion axis counters
// assumes svma_pkg, the design and the master model are compiled first
`timescale 1ns/1ps
module tb_top;
    import svma_pkg::*;
    localparam int MS_P = 8;
    logic clk_sys, nrst, enc_step, enc_dir, cmd_pulse_a, cmd_pulse_b;
    logic capture_strobe_input, stored_path_mode, path_trigger_input;
    logic path_select_bit0, path_select_bit1, path_select_bit2;
    logic axis_wr, mon_rd, mon_valid, mon_unknown;
    logic capture_taken, capture_ok, path_busy, path_done;
    svma_pfmt_e pulse_format_param;
    svma_csrc_e capture_axis_param;
    svma_wsel_e axis_wsel;
    logic [AXIS_W-1:0] gear_numerator_param, gear_denominator_param;
    logic [AXIS_W-1:0] path_target, axis_wdata, mon_data, time_axis;
    logic [AXIS_W-1:0] panel_monitor_value_word, enc_rev_count;
    logic signed [AXIS_W-1:0] encoder_axis_param, pulse_axis_param;
    logic signed [AXIS_W-1:0] capture_axis, capture_data, path_axis;
    logic [VER_W-1:0] dsp_fw_version, pld_fw_version, alarm_code;
    logic [CODE_W-1:0] panel_code, mon_code;
    logic [2:0] path_index;
    int err_total, cmp_count;
    svma_axis_counters #(.MS_CYCLES_P(MS_P)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .enc_step(enc_step),
        .enc_dir(enc_dir), .cmd_pulse_a(cmd_pulse_a),
        .cmd_pulse_b(cmd_pulse_b), .pulse_format_param(pulse_format_param),
        .gear_numerator_param(gear_numerator_param),
        .gear_denominator_param(gear_denominator_param),
        .capture_axis_param(capture_axis_param),
        .capture_strobe_input(capture_strobe_input),
        .stored_path_mode(stored_path_mode),
        .path_trigger_input(path_trigger_input),
        .path_select_bit0(path_select_bit0),
        .path_select_bit1(path_select_bit1),
        .path_select_bit2(path_select_bit2), .path_target(path_target),
        .axis_wr(axis_wr), .axis_wsel(axis_wsel), .axis_wdata(axis_wdata),
        .dsp_fw_version(dsp_fw_version), .pld_fw_version(pld_fw_version),
        .alarm_code(alarm_code), .panel_code(panel_code), .mon_rd(mon_rd),
        .mon_code(mon_code), .mon_data(mon_data), .mon_valid(mon_valid),
        .mon_unknown(mon_unknown),
        .panel_monitor_value_word(panel_monitor_value_word),
        .encoder_axis_param(encoder_axis_param),
        .enc_rev_count(enc_rev_count), .pulse_axis_param(pulse_axis_param),
        .capture_axis(capture_axis), .capture_data(capture_data),
        .capture_taken(capture_taken), .capture_ok(capture_ok),
        .path_axis(path_axis), .path_busy(path_busy),
        .path_done(path_done), .path_index(path_index),
        .time_axis(time_axis));
    svma_master_model i_master (
        .clk_sys(clk_sys), .cmd_pulse_a(cmd_pulse_a),
        .cmd_pulse_b(cmd_pulse_b), .path_select_bit0(path_select_bit0),
        .path_select_bit1(path_select_bit1),
        .path_select_bit2(path_select_bit2),
        .path_trigger_input(path_trigger_input));
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic check(input logic [AXIS_W-1:0] got,
                         input logic [AXIS_W-1:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic wait_hi(ref logic sig, input int lim);
        int i;
        i = 0;
        while (sig !== 1'b1 && i < lim) begin
            tick();
            i++;
        end
        if (sig !== 1'b1) begin
            err_total++;
            $display("BAD at %0t: wait ran out", $time);
            stop_test();
        end
    endtask : wait_hi
    task automatic mon_read(input logic [CODE_W-1:0] code);
        mon_code = code;
        mon_rd = 1'b1;
        tick();
        mon_rd = 1'b0;
        wait_hi(mon_valid, 3);
    endtask : mon_read
    task automatic axis_write(input svma_wsel_e sel,
                              input logic [AXIS_W-1:0] d);
        axis_wsel = sel;
        axis_wdata = d;
        axis_wr = 1'b1;
        tick();
        axis_wr = 1'b0;
        tick();
    endtask : axis_write
    task automatic enc_pulse(input logic down);
        enc_dir = down;
        enc_step = 1'b1;
        tick();
        enc_step = 1'b0;
        tick(2);
    endtask : enc_pulse
    function automatic int units(input svma_pfmt_e f);
        return (f == PF_QUAD) ? 4 : 1;
    endfunction : units
    // ************************************************
    // clock, watchdog and main sequence
    // ************************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        $display("BAD at %0t: run limit reached", $time);
        stop_test();
    end
    initial begin : main
        logic [AXIS_W-1:0] base, v;
        int n;
        {nrst, enc_step, enc_dir, capture_strobe_input} = 4'h0;
        {stored_path_mode, axis_wr, mon_rd} = 3'h0;
        axis_wsel = WS_PULSE;
        axis_wdata = AXIS_RST;
        mon_code = 8'h00;
        pulse_format_param = PF_STEP_DIR;
        capture_axis_param = CS_PULSE;
        gear_numerator_param = 32'h0000_0001;
        gear_denominator_param = 32'h0000_0001;
        path_target = AXIS_RST;
        n = $urandom(32'hC54BCDE2);
        dsp_fw_version = 16'($urandom);
        pld_fw_version = 16'($urandom);
        alarm_code = 16'($urandom);
        panel_code = MON_ALARM_CODE;
        repeat (20) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        tick();
        check(pulse_axis_param | encoder_axis_param | capture_axis, 0, "rst");
        $display("test reset done");
        mon_read(MON_FW_VERSION);
        check(mon_data[15:0], dsp_fw_version, "fw low");
        check(mon_data[31:16], pld_fw_version, "fw high");
        mon_read(MON_ALARM_CODE);
        check(mon_data, {16'h0000, alarm_code}, "alarm");
        check(mon_unknown, 1'b0, "known code");
        check(panel_monitor_value_word, {16'h0000, alarm_code}, "panel");
        mon_read(8'h01);
        check(mon_unknown, 1'b1, "unmapped flag");
        check(mon_data, AXIS_RST, "unmapped data");
        $display("test monitor done");
        base = capture_axis;
        axis_write(WS_CAPTURE, $urandom);
        check(capture_axis, base, "early capture write");
        for (int f = 0; f < 3; f++) begin
            pulse_format_param = svma_pfmt_e'(f);
            tick();
            base = pulse_axis_param;
            v = capture_axis;
            n = $urandom_range(5, 2);
            repeat (n) i_master.pulse(pulse_format_param, 1'b0);
            i_master.pulse(pulse_format_param, 1'b1);
            check(pulse_axis_param, base + (n - 1) * units(pulse_format_param),
                  "pulse count");
            check(capture_axis, v + (n - 1) * units(pulse_format_param),
                  "capture on pulse");
        end
        $display("test pulse formats done");
        pulse_format_param = PF_STEP_DIR;
        axis_write(WS_PULSE, 32'h7FFF_FFFF);
        check(pulse_axis_param, 32'h7FFF_FFFF, "pulse write");
        i_master.pulse(PF_STEP_DIR, 1'b0);
        check(pulse_axis_param, 32'h8000_0000, "wrap");
        v = capture_axis;
        capture_strobe_input = 1'b1;
        tick();
        check(capture_ok, 1'b1, "capture ok");
        tick();
        capture_strobe_input = 1'b0;
        check(capture_ok, 1'b0, "capture ok pulse");
        check(capture_data, v, "capture data");
        check(capture_taken, 1'b1, "taken");
        v = $urandom;
        axis_write(WS_CAPTURE, v);
        check(capture_axis, v, "capture redefine");
        $display("test capture done");
        capture_axis_param = CS_ENCODER;
        enc_pulse(1'b1);
        check(enc_rev_count, COUNTS_PER_REV - 1, "rev count");
        gear_numerator_param = 32'h0000_0002;
        base = encoder_axis_param;
        v = capture_axis;
        n = 2 * $urandom_range(6, 2);
        repeat (n) enc_pulse(1'b0);
        check(encoder_axis_param, base + n / 2, "gear scale");
        check(capture_axis, v + n / 2, "capture on encoder");
        $display("test encoder done");
        base = time_axis;
        tick(MS_P * 5);
        check(time_axis - base, 5, "time ticks");
        $display("test time done");
        i_master.launch(3'h5);
        check(path_busy, 1'b0, "trigger outside mode");
        stored_path_mode = 1'b1;
        n = $urandom_range(7, 1);
        path_target = path_axis + $urandom_range(30, 5);
        i_master.launch(n[2:0]);
        check({path_busy, path_index}, {1'b1, n[2:0]}, "path start");
        wait_hi(path_done, 100);
        check(path_axis, path_target, "path end");
        $display("test path done");
        stop_test();
    end : main
endmodule : tb_top
